/* File: src/pic_timer_defs.vh */
`ifndef PIC_TIMER_DEFS_VH
`define PIC_TIMER_DEFS_VH

// port decode on io_addr
`define PIC_ADDR_CW 2'h3
// control word field positions
`define PIC_CW_SC_HI 7
`define PIC_CW_SC_LO 6
`define PIC_CW_RW_HI 5
`define PIC_CW_RW_LO 4
`define PIC_CW_MODE_HI 3
`define PIC_CW_MODE_LO 1
`define PIC_CW_BCD 0
// read-back command bits, active low selects
`define PIC_RB_LATCH_COUNT_SELECT 5
`define PIC_RB_LATCH_STATUS_SELECT 4
`define PIC_SC_READBACK 2'h3
// read/write formats
`define PIC_RW_LATCH 2'h0
`define PIC_RW_LSB 2'h1
`define PIC_RW_MSB 2'h2
`define PIC_RW_BOTH 2'h3
// modes
`define PIC_MODE0 3'h0
`define PIC_MODE1 3'h1
`define PIC_MODE2 3'h2
`define PIC_MODE3 3'h3
`define PIC_MODE4 3'h4
`define PIC_MODE5 3'h5
// timer tick divider
`define PIC_OSC_DIV 4'hc
`define PIC_OSC_DIV_LAST 4'hb
`define PIC_OSC_DIV_HALF_LAST 4'h5
`define PIC_OSC_DIV_HALF 4'h6
// reset values
`define PIC_RST_CW 6'h00
`define PIC_RST_COUNT 16'h0000
`define PIC_RST_BYTE 8'h00

`endif

/* File: src/pic_timer.v */
// Behaviour
// - latch command freezes count until read
// - repeated latch without read is ignored
// - read-back returns status, then count bytes
// - repeated read-back ignored; latches persist until read
// - timer tick is oscillator divided by twelve
// - mode 0 output low until zero count
// - mode 0 load tick not counted; gate enables
// - mode 0 count loads on next tick
// - mode 0 loads with gate low, waits
// - mode 1 trigger starts N-tick low pulse
// - mode 1 retrigger reloads and extends pulse
// - mode 2 one low tick every N
// - mode 2 gate low forces high; trigger reloads
// - mode 2 new count loads at cycle end
// - mode 3 square wave, odd high longer
// - mode 4 strobe low N+1 ticks after write
// - mode 4 new count restarts sequence
// - mode 5 strobe N+1 ticks after trigger
// - mode 5 new count used at next trigger
// - gate level sampled on tick rise
// - gate edge flip-flop sampled, then cleared
// - count loads/decrements on tick fall; wraps
// - counters 0 and 1 gates tied low
`timescale 1ns/100ps
`include "pic_timer_defs.vh"

module pic_timer (
  input wire clk_sys,
  input wire rst_b,
  input wire clk_en,
  input wire oscillator_input,
  input wire counter2_gate_input,
  input wire io_wr,
  input wire io_rd,
  input wire [1:0] io_addr,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  output wire timer_tick,
  output wire counter0_output,
  output wire counter1_output,
  output wire counter2_output
);

  reg osc_prev_q;
  reg [3:0] div_q;
  reg tick_q;
  reg tick_rise_q;
  reg tick_fall_q;
  wire osc_edge;
  wire [2:0] gate_vec;
  wire [2:0] cnt_out;
  wire [7:0] rd_byte [0:2];

  assign osc_edge = oscillator_input & ~osc_prev_q;
  // only counter 2 has a usable gate
  assign gate_vec = {counter2_gate_input, 1'b0, 1'b0};
  assign timer_tick = tick_q;
  assign counter0_output = cnt_out[0];
  assign counter1_output = cnt_out[1];
  assign counter2_output = cnt_out[2];

  // tick high for six oscillator periods, low for six
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      osc_prev_q <= 1'b0;
      div_q <= 4'h0;
      tick_q <= 1'b0;
      tick_rise_q <= 1'b0;
      tick_fall_q <= 1'b0;
    end else if (clk_en) begin
      osc_prev_q <= oscillator_input;
      tick_rise_q <= osc_edge && (div_q == `PIC_OSC_DIV_LAST);
      tick_fall_q <= osc_edge && (div_q == `PIC_OSC_DIV_HALF_LAST);
      if (osc_edge) begin
        div_q <= (div_q == `PIC_OSC_DIV_LAST) ? 4'h0 : div_q + 4'h1;
        tick_q <= (div_q == `PIC_OSC_DIV_LAST) ||
          ((div_q < `PIC_OSC_DIV_HALF_LAST) && (div_q != `PIC_OSC_DIV_LAST));
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      io_rdata <= `PIC_RST_BYTE;
    end else if (clk_en && io_rd) begin
      io_rdata <= (io_addr == `PIC_ADDR_CW) ? `PIC_RST_BYTE : rd_byte[io_addr];
    end
  end

  function [15:0] dec_cnt;
    input [15:0] v;
    input bcd;
    reg [15:0] r;
    reg borrow;
    integer k;
    begin
      r = v;
      borrow = 1'b1;
      if (!bcd) begin
        r = v - 16'h0001;
      end else begin
        for (k = 0; k < 4; k = k + 1) begin
          if (borrow) begin
            if (r[4*k +: 4] == 4'h0) begin
              r[4*k +: 4] = 4'h9;
            end else begin
              r[4*k +: 4] = r[4*k +: 4] - 4'h1;
              borrow = 1'b0;
            end
          end
        end
      end
      dec_cnt = r;
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_cnt
      reg [5:0] cw_q;
      reg [7:0] cil_q;
      reg [7:0] cih_q;
      reg [15:0] ce_q;
      reg [15:0] ol_q;
      reg [7:0] st_q;
      reg cl_q;
      reg sl_q;
      reg wr_msb_q;
      reg rd_msb_q;
      reg null_q;
      reg out_q;
      reg armed_q;
      reg lp_q;
      reg gprev_q;
      reg gff_q;
      reg trig_q;
      reg gs_q;
      wire [2:0] mode;
      wire [1:0] rw;
      wire [15:0] cnt;
      wire [15:0] dec;
      wire [16:0] n17;
      wire [15:0] half_hi;
      wire [15:0] half_lo;
      wire gate;
      wire gedge;
      wire wr_cw;
      wire wr_data;
      wire rd_data;
      wire rb_sel;
      wire data_done;
      wire rd_hi;
      wire [15:0] rd_src;

      assign gate = gate_vec[i];
      assign gedge = gate & ~gprev_q;
      // modes 6 and 7 alias 2 and 3
      assign mode = (cw_q[3:2] == 2'h3) ? {1'b0, cw_q[2:1]} : cw_q[3:1];
      assign rw = cw_q[5:4];
      assign cnt = {cih_q, cil_q};
      assign dec = dec_cnt(ce_q, cw_q[0]);
      assign n17 = (cnt == 16'h0000) ? 17'h10000 : {1'b0, cnt};
      assign half_hi = n17[16:1] + {15'h0000, n17[0]};
      assign half_lo = n17[16:1];
      assign wr_cw = io_wr && (io_addr == `PIC_ADDR_CW) &&
        (io_wdata[`PIC_CW_SC_HI:`PIC_CW_SC_LO] == i);
      assign rb_sel = io_wr && (io_addr == `PIC_ADDR_CW) &&
        (io_wdata[`PIC_CW_SC_HI:`PIC_CW_SC_LO] == `PIC_SC_READBACK) && io_wdata[i+1];
      assign wr_data = io_wr && (io_addr == i);
      assign rd_data = io_rd && (io_addr == i);
      assign data_done = wr_data && ((rw != `PIC_RW_BOTH) || wr_msb_q);
      assign rd_hi = (rw == `PIC_RW_MSB) || ((rw == `PIC_RW_BOTH) && rd_msb_q);
      assign rd_src = cl_q ? ol_q : ce_q;
      assign rd_byte[i] = sl_q ? st_q : (rd_hi ? rd_src[15:8] : rd_src[7:0]);
      assign cnt_out[i] = out_q;

      always @(posedge clk_sys) begin
        if (!rst_b) begin
          cw_q <= `PIC_RST_CW;
          cil_q <= `PIC_RST_BYTE;
          cih_q <= `PIC_RST_BYTE;
          ce_q <= `PIC_RST_COUNT;
          ol_q <= `PIC_RST_COUNT;
          st_q <= `PIC_RST_BYTE;
          cl_q <= 1'b0;
          sl_q <= 1'b0;
          wr_msb_q <= 1'b0;
          rd_msb_q <= 1'b0;
          null_q <= 1'b0;
          out_q <= 1'b0;
          armed_q <= 1'b0;
          lp_q <= 1'b0;
          gprev_q <= 1'b0;
          gff_q <= 1'b0;
          trig_q <= 1'b0;
          gs_q <= 1'b0;
        end else if (clk_en) begin
          gprev_q <= gate;
          // edge caught in the sampling cycle is not lost
          if (tick_rise_q) begin
            gs_q <= gate;
            trig_q <= gff_q | gedge;
            gff_q <= 1'b0;
          end else if (gedge) begin
            gff_q <= 1'b1;
          end
          if (tick_fall_q) begin
            trig_q <= 1'b0;
            case (mode)
              `PIC_MODE0, `PIC_MODE4: begin
                if (lp_q) begin
                  ce_q <= cnt;
                  lp_q <= 1'b0;
                  null_q <= 1'b0;
                  armed_q <= 1'b1;
                end else if (gs_q) begin
                  ce_q <= dec;
                  if (mode == `PIC_MODE0 && ce_q == 16'h0001) begin
                    out_q <= 1'b1;
                  end
                  if (mode == `PIC_MODE4) begin
                    out_q <= ~(armed_q && ce_q == 16'h0001);
                    if (ce_q == 16'h0001) begin
                      armed_q <= 1'b0;
                    end
                  end
                end
              end
              `PIC_MODE1, `PIC_MODE5: begin
                if (trig_q && !null_q) begin
                  ce_q <= cnt;
                  armed_q <= 1'b1;
                  out_q <= (mode == `PIC_MODE5);
                end else if (trig_q && null_q && !lp_q) begin
                  ce_q <= cnt;
                  null_q <= 1'b0;
                  armed_q <= 1'b1;
                  out_q <= (mode == `PIC_MODE5);
                end else begin
                  ce_q <= dec;
                  if (mode == `PIC_MODE1) begin
                    if (armed_q && ce_q == 16'h0001) begin
                      out_q <= 1'b1;
                      armed_q <= 1'b0;
                    end
                  end else begin
                    out_q <= ~(armed_q && ce_q == 16'h0001);
                    if (ce_q == 16'h0001) begin
                      armed_q <= 1'b0;
                    end
                  end
                end
              end
              `PIC_MODE2: begin
                if (lp_q || trig_q) begin
                  ce_q <= cnt;
                  lp_q <= 1'b0;
                  null_q <= 1'b0;
                  armed_q <= 1'b1;
                  out_q <= 1'b1;
                end else if (gs_q && armed_q) begin
                  if (ce_q == 16'h0001) begin
                    ce_q <= cnt;
                    null_q <= 1'b0;
                    out_q <= 1'b1;
                  end else begin
                    ce_q <= dec;
                    out_q <= (dec != 16'h0001);
                  end
                end
              end
              `PIC_MODE3: begin
                if (lp_q || trig_q) begin
                  ce_q <= half_hi;
                  lp_q <= 1'b0;
                  null_q <= 1'b0;
                  armed_q <= 1'b1;
                  out_q <= 1'b1;
                end else if (gs_q && armed_q) begin
                  if (ce_q == 16'h0001) begin
                    out_q <= ~out_q;
                    ce_q <= out_q ? half_lo : half_hi;
                    null_q <= 1'b0;
                  end else begin
                    ce_q <= ce_q - 16'h0001;
                  end
                end
              end
              default: begin
                ce_q <= ce_q;
              end
            endcase
          end
          // gate low forces the output high without waiting for a tick
          if ((mode == `PIC_MODE2 || mode == `PIC_MODE3) && !gate) begin
            out_q <= 1'b1;
          end
          if (wr_data) begin
            case (rw)
              `PIC_RW_LSB: begin
                cil_q <= io_wdata;
                cih_q <= 8'h00;
              end
              `PIC_RW_MSB: begin
                cil_q <= 8'h00;
                cih_q <= io_wdata;
              end
              default: begin
                if (!wr_msb_q) begin
                  cil_q <= io_wdata;
                end else begin
                  cih_q <= io_wdata;
                end
                wr_msb_q <= ~wr_msb_q;
              end
            endcase
          end
          if (data_done) begin
            null_q <= 1'b1;
            if (mode == `PIC_MODE0 || mode == `PIC_MODE4) begin
              lp_q <= 1'b1;
            end
            if ((mode == `PIC_MODE2 || mode == `PIC_MODE3) && !armed_q) begin
              lp_q <= 1'b1;
            end
            if (mode == `PIC_MODE0) begin
              out_q <= 1'b0;
            end
          end
          if (rd_data) begin
            if (sl_q) begin
              sl_q <= 1'b0;
            end else if (rw == `PIC_RW_BOTH && !rd_msb_q) begin
              rd_msb_q <= 1'b1;
            end else begin
              rd_msb_q <= 1'b0;
              cl_q <= 1'b0;
            end
          end
          if ((wr_cw && io_wdata[`PIC_CW_RW_HI:`PIC_CW_RW_LO] == `PIC_RW_LATCH) ||
              (rb_sel && !io_wdata[`PIC_RB_LATCH_COUNT_SELECT])) begin
            if (!cl_q) begin
              ol_q <= ce_q;
              cl_q <= 1'b1;
            end
          end
          if (rb_sel && !io_wdata[`PIC_RB_LATCH_STATUS_SELECT] && !sl_q) begin
            st_q <= {out_q, null_q, cw_q};
            sl_q <= 1'b1;
          end
          if (wr_cw && io_wdata[`PIC_CW_RW_HI:`PIC_CW_RW_LO] != `PIC_RW_LATCH) begin
            cw_q <= io_wdata[5:0];
            out_q <= (io_wdata[3:1] != `PIC_MODE0);
            cl_q <= 1'b0;
            sl_q <= 1'b0;
            wr_msb_q <= 1'b0;
            rd_msb_q <= 1'b0;
            null_q <= 1'b1;
            armed_q <= 1'b0;
            lp_q <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // pic_timer

/* File: bench/pic_timer_chk.sv */
`timescale 1ns/100ps
module pic_timer_chk (
  input wire clk_sys,
  input wire rst_b,
  input wire oscillator_input,
  input wire counter2_gate_input,
  input wire io_wr,
  input wire io_rd,
  input wire [1:0] io_addr,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire timer_tick,
  input wire counter0_output,
  input wire counter2_output
);
  reg [2:0] m0_q;
  reg [2:0] m2_q;
  reg [6:0] glow_q;
  reg [6:0] quiet_q;
  reg gate_q;
  // latch commands carry format 0 and must not disturb the mode copy
  wire mw = io_wr && io_addr == 2'h3 && io_wdata[5:4] != 2'h0;
  always @(posedge clk_sys) begin
    gate_q <= counter2_gate_input;
    if (!rst_b) begin
      m0_q <= 3'h0;
      m2_q <= 3'h0;
    end else if (mw && io_wdata[7:6] == 2'h0) begin
      m0_q <= io_wdata[3:1];
    end else if (mw && io_wdata[7:6] == 2'h2) begin
      m2_q <= io_wdata[3:1];
    end
    if (counter2_gate_input || !rst_b) glow_q <= 7'h00;
    else if (glow_q != 7'h7f) glow_q <= glow_q + 7'h01;
    if ((counter2_gate_input && !gate_q) || !rst_b) quiet_q <= 7'h00;
    else if (quiet_q != 7'h7f) quiet_q <= quiet_q + 7'h01;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_tick_on_osc: assert property ($changed(timer_tick) |->
    ($past(oscillator_input) && !$past(oscillator_input, 2)) || ($past(oscillator_input, 2) && !$past(oscillator_input, 3)))
    else $error("tick moved without an oscillator edge");
  chk_cw_sets_high: assert property (mw && io_wdata[7:6] == 2'h2 && io_wdata[3:1] != 3'h0 |-> ##[1:2] counter2_output)
    else $error("control word did not raise counter 2 output");
  chk_gate_forces_high: assert property (((m2_q == 3'h2 || m2_q == 3'h3) && !counter2_gate_input) [*2] |-> counter2_output)
    else $error("gate low did not force output high");
  chk_strobe_short: assert property ($fell(counter2_output) && (m2_q == 3'h2 || m2_q == 3'h4 || m2_q == 3'h5)
    |-> ##[1:60] counter2_output) else $error("strobe longer than one tick");
  chk_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data changed without a read");
  chk_halt_gate_low: assert property (glow_q > 7'h64 && !io_wr && !$past(io_wr) &&
    ((m2_q == 3'h0 && !counter2_output) || (m2_q == 3'h4 && counter2_output)) |=> $stable(counter2_output))
    else $error("output moved while gate held low");
  chk_m1_no_trig: assert property (m2_q == 3'h1 && quiet_q > 7'h64 && counter2_output && !io_wr |=> counter2_output)
    else $error("one-shot fired without a trigger");
  chk_c0_no_trig: assert property (m0_q == 3'h1 && counter0_output && !io_wr |=> counter0_output)
    else $error("counter 0 one-shot fired");
  cover property (m2_q == 3'h3 && $rose(counter2_output));
  cover property (m2_q == 3'h1 && $fell(counter2_output));
  cover property (io_rd && io_addr == 2'h2);
endmodule // pic_timer_chk

bind pic_timer pic_timer_chk i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .oscillator_input(oscillator_input),
  .counter2_gate_input(counter2_gate_input), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .timer_tick(timer_tick), .counter0_output(counter0_output),
  .counter2_output(counter2_output));

/* File: bench/pic_host.sv */
`timescale 1ns/100ps
module pic_host (
  input wire clk_sys,
  output reg io_wr,
  output reg io_rd,
  output reg [1:0] io_addr,
  output reg [7:0] io_wdata,
  input wire [7:0] io_rdata
);
  reg [7:0] rd_q;
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 2'h0;
    io_wdata = 8'h00;
  end
  // released lines show the inverse so stale values are never mistaken for data
  task wr(input [1:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      io_wr <= 1'b1;
      io_addr <= a;
      io_wdata <= d;
      @(posedge clk_sys);
      io_wr <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
    end
  endtask
  task rd(input [1:0] a);
    begin
      @(posedge clk_sys);
      io_rd <= 1'b1;
      io_addr <= a;
      @(posedge clk_sys);
      io_rd <= 1'b0;
      io_addr <= ~a;
      @(posedge clk_sys);
      #1 rd_q = io_rdata;
    end
  endtask
  task prog(input [1:0] c, input [2:0] m, input [15:0] v);
    begin
      wr(2'h3, {c, 2'h3, m, 1'b0});
      wr(c, v[7:0]);
      wr(c, v[15:8]);
    end
  endtask
endmodule // pic_host

/* File: bench/tb.sv */
`timescale 1ns/100ps
module tb;
  reg clk_sys;
  reg rst_b;
  reg clk_en;
  reg oscillator_input;
  reg counter2_gate_input;
  reg [1:0] oc_q;
  wire io_wr;
  wire io_rd;
  wire [1:0] io_addr;
  wire [7:0] io_wdata;
  wire [7:0] io_rdata;
  wire timer_tick;
  wire counter0_output;
  wire counter1_output;
  wire counter2_output;
  integer err_total;
  integer compares;
  integer n;
  integer cyc;
  pic_timer i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .oscillator_input(oscillator_input),
    .counter2_gate_input(counter2_gate_input), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .timer_tick(timer_tick), .counter0_output(counter0_output),
    .counter1_output(counter1_output), .counter2_output(counter2_output));
  pic_host i_host (.clk_sys(clk_sys), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // oscillator at a quarter of the clock, so one tick spans 48 clocks
  always @(posedge clk_sys) begin
    oc_q <= oc_q + 2'h1;
    oscillator_input <= oc_q[1];
  end
  task results;
    begin
      if (err_total == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task check(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("wrong value %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // counts tick falls until counter 2 output reaches lvl, or until the tick falls if sy is set
  task ticks(input lvl, input sy);
    reg p;
    integer i;
    begin
      n = 0;
      p = timer_tick;
      for (i = 0; i < 3000 && (sy ? n == 0 : counter2_output !== lvl); i = i + 1) begin
        @(posedge clk_sys);
        #1;
        if (p === 1'b1 && timer_tick === 1'b0) n = n + 1;
        p = timer_tick;
      end
      cyc = i;
      if (i == 3000) begin
        err_total = err_total + 1;
        results;
      end
    end
  endtask
  task gate(input v);
    @(posedge clk_sys) counter2_gate_input <= v;
  endtask
  task t_mode0;
    begin
      ticks(1'b0, 1'b1);
      ticks(1'b0, 1'b1);
      check("tick len", 16'h0030, cyc[15:0]);
      i_host.prog(2'h2, 3'h0, 16'h0004);
      repeat (2) @(posedge clk_sys);
      #1 check("m0 out", 16'h0000, {15'h0000, counter2_output});
      ticks(1'b1, 1'b0);
      check("m0 ticks", 16'h0005, n[15:0]);
    end
  endtask
  task t_mode23;
    begin
      i_host.prog(2'h2, 3'h2, 16'h0003);
      ticks(1'b0, 1'b0);
      ticks(1'b1, 1'b0);
      check("m2 low", 16'h0001, n[15:0]);
      ticks(1'b0, 1'b0);
      check("m2 high", 16'h0002, n[15:0]);
      i_host.prog(2'h2, 3'h3, 16'h0005);
      ticks(1'b0, 1'b0);
      ticks(1'b1, 1'b0);
      check("m3 low", 16'h0002, n[15:0]);
      ticks(1'b0, 1'b0);
      check("m3 high", 16'h0003, n[15:0]);
      gate(1'b0);
      repeat (3) @(posedge clk_sys);
      #1 check("m3 gate", 16'h0001, {15'h0000, counter2_output});
      gate(1'b1);
    end
  endtask
  task t_mode4;
    begin
      ticks(1'b0, 1'b1);
      i_host.prog(2'h2, 3'h4, 16'h0003);
      ticks(1'b0, 1'b0);
      check("m4 wait", 16'h0004, n[15:0]);
      ticks(1'b1, 1'b0);
      check("m4 low", 16'h0001, n[15:0]);
    end
  endtask
  // trigger placed just after a tick fall so the next tick pulse is a whole one
  task t_trig(input [2:0] m, input [15:0] v, input [15:0] e0, input [15:0] e1);
    begin
      gate(1'b0);
      i_host.prog(2'h2, m, v);
      ticks(1'b0, 1'b1);
      gate(1'b1);
      ticks(1'b0, 1'b0);
      check("tr wait", e0, n[15:0]);
      ticks(1'b1, 1'b0);
      check("tr low", e1, n[15:0]);
    end
  endtask
  task t_latch;
    begin
      i_host.prog(2'h0, 3'h1, 16'h0005);
      i_host.prog(2'h1, 3'h0, 16'h0004);
      gate(1'b0);
      i_host.prog(2'h2, 3'h0, 16'h1234);
      repeat (120) @(posedge clk_sys);
      i_host.wr(2'h3, 8'hc8);
      i_host.wr(2'h3, 8'hc8);
      i_host.rd(2'h2);
      check("status", 16'h0030, {8'h00, i_host.rd_q});
      i_host.rd(2'h2);
      check("rb lsb", 16'h0034, {8'h00, i_host.rd_q});
      i_host.rd(2'h2);
      check("rb msb", 16'h0012, {8'h00, i_host.rd_q});
      i_host.wr(2'h3, 8'h80);
      gate(1'b1);
      repeat (150) @(posedge clk_sys);
      i_host.wr(2'h3, 8'h80);
      gate(1'b0);
      i_host.rd(2'h2);
      check("lt lsb", 16'h0034, {8'h00, i_host.rd_q});
      i_host.rd(2'h2);
      check("lt msb", 16'h0012, {8'h00, i_host.rd_q});
      check("c0 out", 16'h0001, {15'h0000, counter0_output});
      check("c1 out", 16'h0000, {15'h0000, counter1_output});
    end
  endtask
  // resume after a whole number of oscillator periods so no false edge is seen
  task t_freeze;
    reg t0;
    begin
      @(posedge clk_sys) clk_en <= 1'b0;
      @(posedge clk_sys);
      #1 t0 = timer_tick;
      repeat (72) @(posedge clk_sys);
      #1 check("frz tick", {15'h0000, t0}, {15'h0000, timer_tick});
      repeat (3) @(posedge clk_sys);
      clk_en <= 1'b1;
    end
  endtask
  initial begin
    err_total = 0;
    compares = 0;
    oc_q = 2'h0;
    oscillator_input = 1'b0;
    clk_en = 1'b1;
    rst_b = 1'b0;
    counter2_gate_input = 1'b1;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_mode0;
    t_mode23;
    t_mode4;
    t_trig(3'h1, 16'h0003, 16'h0001, 16'h0003);
    t_trig(3'h5, 16'h0002, 16'h0003, 16'h0001);
    t_latch;
    t_freeze;
    results;
  end
endmodule // tb
